// ===== src/sar_top.sv
`timescale 1ns/10ps
module sar_top
   import sar_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        convert_start_i,
   input  wire logic        serial_clock_i,
   input  wire logic        chain_select_in_i,
   input  wire logic [17:0] sample_code_i,
   input  wire logic        over_range_i,
   input  wire logic        under_range_i,
   output logic             serial_result_out_o,
   output logic             serial_result_out_oe_n_o
);
   localparam int A_CONV_LAT = CONV_CYC;

   logic [2:0]  sync;
   logic        cnv_s;
   logic        sclk_s;
   logic        sdi_s;
   logic        cnv_d;
   logic        sclk_d;
   logic        cnv_rise;
   logic        sclk_fall;
   sar_state_e  state;
   logic [4:0]  count;
   logic        done;
   logic        chain_mode;
   logic        busy_ind;
   logic        cs_enable;
   logic [17:0] result;
   logic [17:0] shreg;
   logic        next_sdo;
   logic [4:0]  conv_age;

   sar_sync sar_sync_inst (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i ({convert_start_i, serial_clock_i, chain_select_in_i}),
      .sync_o  (sync)
   );
   assign cnv_s  = sync[2];
   assign sclk_s = sync[1];
   assign sdi_s  = sync[0];

   function automatic logic [17:0] saturate(input logic [17:0] code, input logic over, input logic under);
      if (over)
         return SAT_POS;
      else if (under)
         return SAT_NEG;
      else
         return code;
   endfunction : saturate

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cnv_d  <= 1'b0;
         sclk_d <= 1'b0;
      end else begin
         cnv_d  <= cnv_s;
         sclk_d <= sclk_s;
      end
   end
   assign cnv_rise  = cnv_s & ~cnv_d;
   assign sclk_fall = sclk_d & ~sclk_s;
   assign done      = (state == SAR_CONVERT) && (count == 5'h01);
   assign cs_enable = ~cnv_s | ~sdi_s;

   // conversion runs off the internal clock only; a rise mid-conversion is ignored
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state <= SAR_IDLE;
         count <= 5'h00;
      end else begin
         case (state)
            SAR_IDLE: begin
               if (cnv_rise) begin
                  state <= SAR_CONVERT;
                  count <= CONV_CYC;
               end
            end
            SAR_CONVERT: begin
               count <= count - 5'h01;
               if (count == 5'h01)
                  state <= SAR_IDLE;
            end
            default: begin
               state <= SAR_IDLE;
               count <= 5'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i)
         chain_mode <= 1'b0;
      else if (cnv_rise && state == SAR_IDLE)
         chain_mode <= ~sdi_s;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i)
         result <= SHIFT_RST;
      else if (done)
         result <= saturate(sample_code_i, over_range_i, under_range_i);
   end

   // busy stays up until the first falling edge, which then reveals the msb
   always_ff @(posedge clock_i) begin
      if (!rst_n_i)
         busy_ind <= 1'b0;
      else if (done)
         busy_ind <= ~chain_mode & cs_enable;
      else if (sclk_fall)
         busy_ind <= 1'b0;
   end

   // in chain mode the host holds convert high while clocking, so no gating here
   always_ff @(posedge clock_i) begin
      if (!rst_n_i)
         shreg <= SHIFT_RST;
      else if (done)
         shreg <= saturate(sample_code_i, over_range_i, under_range_i);
      else if (sclk_fall && chain_mode)
         shreg <= {shreg[16:0], sdi_s};
      else if (sclk_fall && !busy_ind && cs_enable)
         shreg <= {shreg[16:0], 1'b0};
   end

   always_comb begin
      if (state == SAR_CONVERT && !chain_mode)
         next_sdo = 1'b1;
      else if (busy_ind)
         next_sdo = 1'b0;
      else
         next_sdo = shreg[17];
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         serial_result_out_o      <= 1'b0;
         serial_result_out_oe_n_o <= 1'b1;
      end else begin
         serial_result_out_o      <= next_sdo;
         serial_result_out_oe_n_o <= ~(chain_mode | cs_enable);
      end
   end

   // assertion helper: cycles since the detected start
   // saturates so a long idle stretch never wraps back into the window
   always_ff @(posedge clock_i) begin
      if (!rst_n_i)
         conv_age <= 5'h00;
      else if (cnv_rise && state == SAR_IDLE)
         conv_age <= 5'h01;
      else if (conv_age != 5'h1f)
         conv_age <= conv_age + 5'h01;
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_start;
      cnv_rise && state == SAR_IDLE;
   endsequence
   sequence s_done_busy;
      done && !chain_mode && cs_enable;
   endsequence
   sequence s_gated_off;
      !chain_mode && !cs_enable && !done;
   endsequence
   sequence s_busy_fall;
      busy_ind && sclk_fall && !done;
   endsequence

   a_mode_latch: assert property (s_start |=> chain_mode == !$past(sdi_s))
      else $error("mode not latched from select at convert rise");
   a_conv_time: assert property (s_start |-> ##A_CONV_LAT done)
      else $error("conversion end not at fixed latency");
   a_conv_alone: assert property (s_start |=> (state == SAR_CONVERT) [*8])
      else $error("conversion stopped early");
   a_cs_enable: assert property (!chain_mode && cs_enable |=> !serial_result_out_oe_n_o)
      else $error("output not enabled with an input low");
   a_cs_release: assert property (!chain_mode && cnv_s && sdi_s |=> serial_result_out_oe_n_o)
      else $error("output not released with both inputs high");
   a_chain_in: assert property (chain_mode && sclk_fall && !done |=> shreg[0] == $past(sdi_s))
      else $error("chain input not shifted in");
   a_shift_msb: assert property (sclk_fall && !done && !busy_ind && (chain_mode || cs_enable)
      |=> shreg[17] == $past(shreg[16]))
      else $error("shift path did not advance");
   a_sat_over: assert property (done && over_range_i |=> result == SAT_POS)
      else $error("over-range not saturated");
   a_sat_under: assert property (done && under_range_i && !over_range_i |=> result == SAT_NEG)
      else $error("under-range not saturated");
   a_busy_low: assert property (s_done_busy |=> busy_ind ##1 !serial_result_out_o)
      else $error("busy indicator did not signal ready");
   a_busy_arm: assert property (done && !chain_mode && !cs_enable |=> !busy_ind)
      else $error("busy armed with both inputs high");
   a_conv_high: assert property (state == SAR_CONVERT && !chain_mode |=> serial_result_out_o)
      else $error("output not high during conversion");
   a_first_bit: assert property (done && !(cs_enable && !chain_mode) |=> ##1
      serial_result_out_o == $past(result[17]))
      else $error("msb not presented after conversion");
   a_conv_window: assert property (done |-> int'(conv_age) + PIPE_CYC inside {[CONV_MIN_CYC:CONV_MAX_CYC]})
      else $error("conversion end outside the allowed window");
   a_chain_oe: assert property (chain_mode |=> !serial_result_out_oe_n_o)
      else $error("output not driven in chain mode");
   a_mode_steady: assert property (!(cnv_rise && state == SAR_IDLE) |=> $stable(chain_mode))
      else $error("mode changed without a convert rise");
   a_gated_hold: assert property (s_gated_off |=> shreg == $past(shreg))
      else $error("shift path moved while deselected");
   a_busy_hold: assert property (busy_ind && !sclk_fall && !done |=> busy_ind)
      else $error("busy indicator dropped without a clock fall");
   a_busy_clear: assert property (s_busy_fall |=> !busy_ind)
      else $error("busy indicator not cleared by clock fall");
   a_result_hold: assert property (!done |=> $stable(result))
      else $error("result changed outside conversion end");
   a_load_shift: assert property (done |=> shreg == result)
      else $error("shift path not loaded with the result");
   a_chain_nobusy: assert property (done && chain_mode |=> !busy_ind)
      else $error("busy indicator armed in chain mode");
endmodule : sar_top

// ===== common/sar_pkg.sv
package sar_pkg;
   localparam int          CODE_W       = 18;
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          CONV_MIN_NS  = 300;
   localparam int          CONV_MAX_NS  = 500;
   localparam int          CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   // pin sync, edge detect and output flop eat cycles of the budget
   localparam int          PIPE_CYC     = 5;
   localparam logic [4:0]  CONV_CYC     = 5'(CONV_MAX_CYC - PIPE_CYC);
   localparam logic [17:0] SAT_POS      = 18'h1ffff;
   localparam logic [17:0] SAT_NEG      = 18'h20000;
   localparam logic [17:0] SHIFT_RST    = 18'h00000;
   typedef enum logic {SAR_IDLE, SAR_CONVERT} sar_state_e;
endpackage : sar_pkg

// ===== src/sar_sync.sv
`timescale 1ns/10ps
module sar_sync (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic [2:0] async_i,
   output logic      [2:0] sync_o
);
   logic [2:0] meta;
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         meta   <= 3'h0;
         sync_o <= 3'h0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : sar_sync

// ===== verification/sar_host_model.sv
`timescale 1ns/10ps
module sar_host_model (
   input  wire logic clock_i,
   input  wire logic sdo_i,
   input  wire logic oe_n_i,
   output logic      convert_o,
   output logic      sclk_o,
   output logic      select_o
);
   logic last = 1'b0;
   logic lvl;
   initial begin
      convert_o = 1'b0;
      sclk_o    = 1'b0;
      select_o  = 1'b1;
   end
   // a released line must not pass for valid data
   always @(posedge clock_i) if (!oe_n_i) last <= sdo_i;
   assign lvl = oe_n_i ? ~last : sdo_i;
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock_i);
   endtask : wait_n
   // busy: select dropped once convert is high
   task automatic start(input logic sel, input logic busy);
      convert_o = 1'b0;
      select_o  = sel;
      wait_n(4);
      convert_o = 1'b1;
      wait_n(1);
      if (busy) select_o = 1'b0;
   endtask : start
   // sclk idles low between frames; short high phase, long low phase to let data land
   task automatic shift(input int n, input logic hold, input logic [35:0] up, output logic [35:0] got);
      convert_o = hold;
      got = '0;
      for (int k = n - 1; k >= 0; k--) begin
         wait_n(6);
         got[k]   = lvl;
         sclk_o   = 1'b1;
         select_o = up[k];
         wait_n(2);
         sclk_o   = 1'b0;
      end
   endtask : shift
endmodule : sar_host_model

// ===== verification/sar_adc_serial_readout_bench.sv
`timescale 1ns/10ps
module sar_adc_serial_readout_bench;
   logic        clock = 1'b0;
   logic        rst_n;
   logic        conv, sclk, sel, over, under, serial_result_out, oe_n;
   logic [17:0] code, e, up18;
   logic [35:0] got;
   logic [31:0] seed = 32'd29864;
   logic [17:0] exp_q[$];
   int          miscompares = 0;
   int          n_tests = 0;
   int          mode;
   always #12.5 clock = ~clock;
   sar_top sar_top_inst (.clock_i(clock), .rst_n_i(rst_n), .convert_start_i(conv), .serial_clock_i(sclk),
      .chain_select_in_i(sel), .sample_code_i(code), .over_range_i(over), .under_range_i(under),
      .serial_result_out_o(serial_result_out), .serial_result_out_oe_n_o(oe_n));
   sar_host_model sar_host_model_inst (.clock_i(clock), .sdo_i(serial_result_out), .oe_n_i(oe_n), .convert_o(conv),
      .sclk_o(sclk), .select_o(sel));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs
   task automatic chk(input logic [35:0] a, input logic [35:0] x);
      n_tests++;
      if (a !== x) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, a, x);
      end
   endtask : chk
   task automatic summarize;
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   initial begin
      #300000;
      miscompares++;
      summarize();
   end
   // 0 gated, 1 gated with busy, 2 chain; i%4 walks the range flags, over beating under
   initial begin
      rst_n = 1'b0;
      {code, over, under} = '0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      for (int i = 0; i < 12; i++) begin
         mode  = i % 3;
         seed  = xs(seed);
         code  = seed[17:0];
         up18  = seed[31:14];
         over  = (i % 4 == 1);
         under = (i % 4 == 1) || (i % 4 == 2);
         exp_q.push_back(over ? 18'h1ffff : under ? 18'h20000 : code);
         sar_host_model_inst.start(mode != 2, mode == 1);
         sar_host_model_inst.wait_n(10);
         chk(oe_n, mode == 0);
         if (mode == 1) chk(serial_result_out, 1);
         sar_host_model_inst.wait_n(9);
         if (mode == 1) chk({oe_n, serial_result_out}, 0);
         sar_host_model_inst.shift(mode == 2 ? 36 : mode == 1 ? 19 : 18, mode == 2, {up18, 18'h3ffff}, got);
         e = exp_q.pop_front();
         case (mode)
            0: chk(got[17:0], e);
            1: chk(got[18:0], {1'b0, e});
            default: chk(got, {e, up18});
         endcase
      end
      summarize();
   end
endmodule : sar_adc_serial_readout_bench
